// ---- rtl/rtcpt_pkg.sv ----
// Purpose: Shared constants for the real-time counter with periodic tick unit.
// Assumes: 32-bit Avalon-MM slave, byte address, register index times four.
// Notes: All offsets live here, with the control, enable and flag field positions and the control, period, compare and source reset values.
package rtcpt_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] RTCPT_CTRL_IDX = 6'h00;        // Counter control.
  localparam logic [5:0] RTCPT_STATUS_IDX = 6'h01;      // Synchronisation busy flags.
  localparam logic [5:0] RTCPT_IRQ_EN_IDX = 6'h02;      // Interrupt enables.
  localparam logic [5:0] RTCPT_FLAGS_IDX = 6'h03;       // Interrupt flags, write one to clear.
  localparam logic [5:0] RTCPT_DEBUG_IDX = 6'h05;       // Counter run-while-halted.
  localparam logic [5:0] RTCPT_SRC_IDX = 6'h07;         // Clock source select.
  localparam logic [5:0] RTCPT_COUNT_IDX = 6'h08;       // Counter value.
  localparam logic [5:0] RTCPT_PERIOD_IDX = 6'h0A;      // Period (top) value.
  localparam logic [5:0] RTCPT_COMPARE_IDX = 6'h0C;     // Compare value.
  localparam logic [5:0] RTCPT_TICK_CTRL_IDX = 6'h10;   // Tick unit control.
  localparam logic [5:0] RTCPT_TICK_STATUS_IDX = 6'h11; // Tick unit busy flag.
  localparam logic [5:0] RTCPT_TICK_IRQ_EN_IDX = 6'h12; // Tick unit interrupt enable.
  localparam logic [5:0] RTCPT_TICK_FLAG_IDX = 6'h13;   // Tick unit flag, write one to clear.
  localparam logic [5:0] RTCPT_TICK_DEBUG_IDX = 6'h15;  // Tick unit run-while-halted.

  // Field positions in the control registers.
  localparam int RTCPT_EN_BIT = 0;        // Enable bit in both control registers.
  localparam int RTCPT_PRESC_LSB = 3;     // Prescaler / period field, four bits.
  localparam int RTCPT_SBY_BIT = 7;       // Standby-run bit of the counter control.
  localparam int RTCPT_OVF_BIT = 0;       // Overflow position in enables and flags.
  localparam int RTCPT_MATCH_BIT = 1;     // Compare position in enables and flags.

  // Reset values.
  localparam logic [7:0] RTCPT_CTRL_RST = 8'h00;
  localparam logic [15:0] RTCPT_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] RTCPT_COMPARE_RST = 16'h0000;
  localparam logic [1:0] RTCPT_SRC_RST = 2'h0;

  // Clock source encodings.
  localparam logic [1:0] RTCPT_SRC_ULP = 2'h0;      // Internal 32K oscillator.
  localparam logic [1:0] RTCPT_SRC_ULP_DIV = 2'h1;  // Internal oscillator divided by 32.
  localparam logic [1:0] RTCPT_SRC_CRYSTAL = 2'h2;  // 32.768 kHz watch crystal.
  localparam logic [1:0] RTCPT_SRC_EXT = 2'h3;      // External clock on the crystal input pin.
  localparam logic [4:0] RTCPT_ULP_DIV_LAST = 5'h1F; // Divide-by-32 terminal count.

  // Tick unit ranges: interrupt periods 4..32768, events 8192 down to 64.
  localparam logic [3:0] RTCPT_TICK_SEL_MIN = 4'h1;  // Selects 4 periods.
  localparam logic [3:0] RTCPT_TICK_SEL_MAX = 4'hE;  // Selects 32768 periods.
  localparam int RTCPT_TICK_EVENTS = 8;              // Event 0 is 8192 periods, event 7 is 64.
  localparam int RTCPT_TICK_EVENT0_LOG2 = 13;        // Log2 of the event 0 interval.

endpackage : rtcpt_pkg

// ---- rtl/rtcpt_top.sv ----
// Purpose: 16-bit real-time counter with prescaler, compare, period and a periodic tick unit.
// Assumes: Reference clock levels arrive synchronous to clock, far slower than it.
// Notes: Counter-domain writes are handed over on the next reference edge.
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
module rtcpt_top
  import rtcpt_pkg::*;
(
  input wire logic clock,                // System clock, 200 MHz.
  input wire logic resetn,               // Asynchronous reset, active low.
  input wire logic [7:0] address,        // Avalon byte address.
  input wire logic read,                 // Avalon read request.
  input wire logic write,                // Avalon write request.
  input wire logic [3:0] byteenable,     // Avalon byte lanes.
  input wire logic [31:0] writedata,     // Avalon write data.
  output logic [31:0] readdata,          // Avalon read data.
  output logic waitrequest,              // Avalon wait request.
  input wire logic ultra_low_power_osc,  // Internal 32K oscillator level.
  input wire logic watch_crystal_osc,    // Watch crystal oscillator level.
  input wire logic crystal_pin_in,       // External clock level on the crystal input pin.
  input wire logic cpu_halted,           // CPU stopped in debug mode.
  input wire logic sleep_standby,        // Device is in standby sleep.
  output logic counter_irq,              // Compare or overflow interrupt request.
  output logic tick_irq,                 // Tick unit interrupt request.
  output logic compare_event,            // One-cycle compare event.
  output logic overflow_event,           // One-cycle overflow event.
  output logic [7:0] tick_event          // One-cycle tick events, 8192 down to 64 periods.
);

  // Complete state of the block.
  typedef struct packed {
    logic ack;               // Second cycle of a bus access.
    logic [31:0] rdata;      // Registered read data.
    logic [7:0] sh_ctrl;     // Control as written by software.
    logic [7:0] act_ctrl;    // Control as used by the counter side.
    logic pend_ctrl;         // Control write awaiting hand-over.
    logic [15:0] sh_count;   // Counter load value.
    logic pend_count;        // Counter load awaiting hand-over.
    logic [15:0] sh_period;  // Period as written.
    logic [15:0] act_period; // Period in use.
    logic pend_period;       // Period awaiting hand-over.
    logic [15:0] sh_compare; // Compare as written.
    logic [15:0] act_compare; // Compare in use.
    logic pend_compare;      // Compare awaiting hand-over.
    logic [7:0] sh_tctrl;    // Tick control as written.
    logic [7:0] act_tctrl;   // Tick control in use.
    logic pend_tctrl;        // Tick control awaiting hand-over.
    logic [1:0] irq_en;      // Compare and overflow interrupt enables.
    logic [1:0] flags;       // Compare and overflow flags.
    logic run_while_halted;  // Counter keeps going under debug halt.
    logic tick_irq_en;       // Tick interrupt enable.
    logic tick_flag;         // Tick interrupt flag.
    logic tick_run_halted;   // Tick unit keeps going under debug halt.
    logic [1:0] source_select; // Reference clock choice.
    logic ulp_prev;          // Previous oscillator level.
    logic xtal_prev;         // Previous crystal level.
    logic ext_prev;          // Previous external clock level.
    logic [4:0] ulp_div;     // Divide-by-32 counter.
    logic [14:0] presc;      // Prescaler counter.
    logic [15:0] count;      // Main counter.
    logic [14:0] tcount;     // Tick unit counter.
    logic ev_compare;        // Compare event pulse.
    logic ev_overflow;       // Overflow event pulse.
    logic [7:0] ev_tick;     // Tick event pulses.
  } rtcpt_state_t;

  rtcpt_state_t st_ff;   // Registered state.
  rtcpt_state_t nxt_st;  // Next state.

  // Merge a 16-bit value with write data according to byte enables.
  function automatic logic [15:0] rtcpt_merge16(input logic [15:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // Mask of the low bits selected by a power-of-two field, 2**sel - 1.
  function automatic logic [14:0] rtcpt_low_mask(input logic [3:0] sel);
    logic [15:0] one_hot;
    one_hot = 16'h0001 << sel;
    return 15'(one_hot - 16'h0001);
  endfunction

  // Combinational outputs: waitrequest from the request inputs and state, the data and request outputs straight from state.
  always_comb begin
    waitrequest = (read | write) & ~st_ff.ack;
    readdata = st_ff.rdata;
    compare_event = st_ff.ev_compare;
    overflow_event = st_ff.ev_overflow;
    tick_event = st_ff.ev_tick;
    counter_irq = |(st_ff.flags & st_ff.irq_en);
    tick_irq = st_ff.tick_flag & st_ff.tick_irq_en;
  end

  // Next-state logic: bus slave, reference edge, prescaler, counter and tick unit.
  always_comb begin
    logic req;
    logic wr_now;
    logic [5:0] idx;
    logic ulp_rise;
    logic div_tick;
    logic src_tick;
    logic main_go;
    logic tick_go;
    logic step;
    logic [14:0] pmask;
    logic [14:0] tnext;
    logic [3:0] tsel;
    logic [31:0] rd;
    logic [1:0] flag_set; // Counter flags that hardware sets in this cycle.
    logic tick_set;       // Tick flag that hardware sets in this cycle.
    req = 1'b0;
    wr_now = 1'b0;
    idx = 6'h00;
    ulp_rise = 1'b0;
    div_tick = 1'b0;
    src_tick = 1'b0;
    main_go = 1'b0;
    tick_go = 1'b0;
    step = 1'b0;
    pmask = 15'h0000;
    tnext = 15'h0000;
    tsel = 4'h0;
    rd = 32'h00000000;
    flag_set = 2'h0;
    tick_set = 1'b0;
    nxt_st = st_ff;
    nxt_st.ev_compare = 1'b0;
    nxt_st.ev_overflow = 1'b0;
    nxt_st.ev_tick = 8'h00;

    // Bus access: one wait cycle, then the write lands and read data stand.
    req = read | write;
    idx = address[7:2];
    wr_now = write & st_ff.ack;
    nxt_st.ack = req & ~st_ff.ack;

    // Read data are captured in the wait cycle.
    case (idx)
      RTCPT_CTRL_IDX: rd = {24'h000000, st_ff.sh_ctrl};
      RTCPT_STATUS_IDX: begin
        rd = {28'h0000000, st_ff.pend_compare, st_ff.pend_period, st_ff.pend_count,
              st_ff.pend_ctrl};
      end
      RTCPT_IRQ_EN_IDX: rd = {30'h00000000, st_ff.irq_en};
      RTCPT_FLAGS_IDX: rd = {30'h00000000, st_ff.flags};
      RTCPT_DEBUG_IDX: rd = {31'h00000000, st_ff.run_while_halted};
      RTCPT_SRC_IDX: rd = {30'h00000000, st_ff.source_select};
      RTCPT_COUNT_IDX: rd = {16'h0000, st_ff.count};
      RTCPT_PERIOD_IDX: rd = {16'h0000, st_ff.sh_period};
      RTCPT_COMPARE_IDX: rd = {16'h0000, st_ff.sh_compare};
      RTCPT_TICK_CTRL_IDX: rd = {24'h000000, st_ff.sh_tctrl};
      RTCPT_TICK_STATUS_IDX: rd = {31'h00000000, st_ff.pend_tctrl};
      RTCPT_TICK_IRQ_EN_IDX: rd = {31'h00000000, st_ff.tick_irq_en};
      RTCPT_TICK_FLAG_IDX: rd = {31'h00000000, st_ff.tick_flag};
      RTCPT_TICK_DEBUG_IDX: rd = {31'h00000000, st_ff.tick_run_halted};
      default: rd = 32'h00000000; // Unmapped addresses read as zero.
    endcase
    if (read & ~st_ff.ack) begin
      nxt_st.rdata = rd;
    end

    // Reference clock edges; the source select drives both functions alike.
    ulp_rise = ultra_low_power_osc & ~st_ff.ulp_prev;
    nxt_st.ulp_prev = ultra_low_power_osc;
    nxt_st.xtal_prev = watch_crystal_osc;
    nxt_st.ext_prev = crystal_pin_in;
    if (ulp_rise) begin
      nxt_st.ulp_div = st_ff.ulp_div + 5'h01;
    end
    div_tick = ulp_rise & (st_ff.ulp_div == RTCPT_ULP_DIV_LAST);
    case (st_ff.source_select)
      RTCPT_SRC_ULP: src_tick = ulp_rise;
      RTCPT_SRC_ULP_DIV: src_tick = div_tick;
      RTCPT_SRC_CRYSTAL: src_tick = watch_crystal_osc & ~st_ff.xtal_prev;
      RTCPT_SRC_EXT: src_tick = crystal_pin_in & ~st_ff.ext_prev;
      default: src_tick = 1'b0;
    endcase

    // Run gating by debug halt for both, by standby sleep for the counter only.
    main_go = st_ff.act_ctrl[RTCPT_EN_BIT]
            & (~cpu_halted | st_ff.run_while_halted)
            & (~sleep_standby | st_ff.act_ctrl[RTCPT_SBY_BIT]);
    tick_go = st_ff.act_tctrl[RTCPT_EN_BIT]
            & (~cpu_halted | st_ff.tick_run_halted);

    // Prescaler: one advance strobe per 2**field reference ticks.
    pmask = rtcpt_low_mask(st_ff.act_ctrl[RTCPT_PRESC_LSB +: 4]);
    if (src_tick & main_go) begin
      nxt_st.presc = st_ff.presc + 15'h0001;
      step = ((st_ff.presc & pmask) == pmask);
    end else if (~st_ff.act_ctrl[RTCPT_EN_BIT]) begin
      nxt_st.presc = 15'h0000; // A stopped counter restarts its prescaler cleanly.
    end

    // Main counter: compare and period are checked at each advance.
    if (step) begin
      if (st_ff.count == st_ff.act_compare) begin
        nxt_st.flags[RTCPT_MATCH_BIT] = 1'b1;
        nxt_st.ev_compare = 1'b1;
        flag_set[RTCPT_MATCH_BIT] = 1'b1;     // Protects the set from a same-cycle clear.
      end
      if (st_ff.count == st_ff.act_period) begin
        nxt_st.count = 16'h0000;
        nxt_st.flags[RTCPT_OVF_BIT] = 1'b1;
        nxt_st.ev_overflow = 1'b1;
        flag_set[RTCPT_OVF_BIT] = 1'b1;       // Protects the set from a same-cycle clear.
      end else begin
        nxt_st.count = st_ff.count + 16'h0001;
      end
    end

    // Tick unit: a free-running count of reference periods.
    tsel = st_ff.act_tctrl[RTCPT_PRESC_LSB +: 4];
    if (src_tick & tick_go) begin
      tnext = st_ff.tcount + 15'h0001;
      nxt_st.tcount = tnext;
      if ((tsel >= RTCPT_TICK_SEL_MIN) && (tsel <= RTCPT_TICK_SEL_MAX) &&
          ((tnext & rtcpt_low_mask(4'(tsel + 4'h1))) == 15'h0000)) begin
        nxt_st.tick_flag = 1'b1;
        tick_set = 1'b1;         // Protects the set from a same-cycle clear.
      end
      for (int k = 0; k < RTCPT_TICK_EVENTS; k++) begin
        nxt_st.ev_tick[k] = ((tnext & rtcpt_low_mask(4'(RTCPT_TICK_EVENT0_LOG2 - k))) == 15'h0000);
      end
    end else if (~st_ff.act_tctrl[RTCPT_EN_BIT]) begin
      nxt_st.tcount = 15'h0000;
    end

    // Hand-over of pending writes at the next reference edge.
    if (src_tick) begin
      if (st_ff.pend_ctrl) begin
        nxt_st.act_ctrl = st_ff.sh_ctrl;
        nxt_st.pend_ctrl = 1'b0;
      end
      if (st_ff.pend_count) begin
        nxt_st.count = st_ff.sh_count;
        nxt_st.pend_count = 1'b0;
      end
      if (st_ff.pend_period) begin
        nxt_st.act_period = st_ff.sh_period;
        nxt_st.pend_period = 1'b0;
      end
      if (st_ff.pend_compare) begin
        nxt_st.act_compare = st_ff.sh_compare;
        nxt_st.pend_compare = 1'b0;
      end
      if (st_ff.pend_tctrl) begin
        nxt_st.act_tctrl = st_ff.sh_tctrl;
        nxt_st.pend_tctrl = 1'b0;
      end
    end

    // Register writes; flags clear by one, a same-cycle set wins.
    if (wr_now & byteenable[0]) begin
      case (idx)
        RTCPT_CTRL_IDX: begin
          nxt_st.sh_ctrl = writedata[7:0];
          nxt_st.pend_ctrl = 1'b1;
        end
        RTCPT_IRQ_EN_IDX: nxt_st.irq_en = writedata[1:0];
        RTCPT_FLAGS_IDX: nxt_st.flags = nxt_st.flags & ~(writedata[1:0] & ~flag_set);
        RTCPT_DEBUG_IDX: nxt_st.run_while_halted = writedata[0];
        RTCPT_SRC_IDX: nxt_st.source_select = writedata[1:0];
        RTCPT_TICK_CTRL_IDX: begin
          nxt_st.sh_tctrl = writedata[7:0];
          nxt_st.pend_tctrl = 1'b1;
        end
        RTCPT_TICK_IRQ_EN_IDX: nxt_st.tick_irq_en = writedata[0];
        RTCPT_TICK_FLAG_IDX: begin
          if (writedata[0] && !tick_set) begin
            nxt_st.tick_flag = 1'b0;
          end
        end
        RTCPT_TICK_DEBUG_IDX: nxt_st.tick_run_halted = writedata[0];
        default: begin
        end
      endcase
    end
    if (wr_now & (|byteenable[1:0])) begin
      case (idx)
        RTCPT_COUNT_IDX: begin
          nxt_st.sh_count = rtcpt_merge16(st_ff.count, writedata, byteenable);
          nxt_st.pend_count = 1'b1;
        end
        RTCPT_PERIOD_IDX: begin
          nxt_st.sh_period = rtcpt_merge16(st_ff.sh_period, writedata, byteenable);
          nxt_st.pend_period = 1'b1;
        end
        RTCPT_COMPARE_IDX: begin
          nxt_st.sh_compare = rtcpt_merge16(st_ff.sh_compare, writedata, byteenable);
          nxt_st.pend_compare = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.sh_ctrl <= RTCPT_CTRL_RST;
      st_ff.act_ctrl <= RTCPT_CTRL_RST;
      st_ff.sh_tctrl <= RTCPT_CTRL_RST;
      st_ff.act_tctrl <= RTCPT_CTRL_RST;
      st_ff.sh_period <= RTCPT_PERIOD_RST;
      st_ff.act_period <= RTCPT_PERIOD_RST;
      st_ff.sh_compare <= RTCPT_COMPARE_RST;
      st_ff.act_compare <= RTCPT_COMPARE_RST;
      st_ff.source_select <= RTCPT_SRC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // rtcpt_top

// ---- sim/rtcpt_top_sva.sv ----
// Purpose: Port-level checks of the real-time counter.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Attached to every top instance by bind.
module rtcpt_checker
  import rtcpt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic counter_irq,
  input wire logic tick_irq,
  input wire logic compare_event,
  input wire logic overflow_event,
  input wire logic [7:0] tick_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the system clock and reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_WAIT_FIRST: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("wait missing in first request cycle");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait cycle");
  AST_WAIT_IDLE: assert property (waitrequest |-> (read || write))
    else $error("wait raised without a request");
  AST_CMP_PULSE: assert property (compare_event |=> !compare_event)
    else $error("compare event longer than one cycle");
  AST_OVF_PULSE: assert property (overflow_event |=> !overflow_event)
    else $error("overflow event longer than one cycle");
  AST_TICK_NEST: assert property (tick_event != 8'h00 |-> (tick_event[6:0] & ~tick_event[7:1]) == 7'h00)
    else $error("longer tick interval fired without shorter one");
  AST_TICK_PULSE: assert property (tick_event != 8'h00 |=> tick_event == 8'h00)
    else $error("tick event longer than one cycle");
  AST_IRQ_RISE: assert property ($rose(counter_irq) |-> compare_event || overflow_event || $past(compare_event)
    || $past(overflow_event) || $past(write))
    else $error("counter request rose without cause");
  AST_IRQ_HOLD: assert property ($fell(counter_irq) |-> $past(write))
    else $error("counter request dropped without a write");
  AST_TICK_HOLD: assert property ($fell(tick_irq) |-> $past(write))
    else $error("tick request dropped without a write");
endmodule // rtcpt_checker

bind rtcpt_top rtcpt_checker u_rtcpt_checker (.clock(clock), .resetn(resetn), .read(read), .write(write),
  .waitrequest(waitrequest), .counter_irq(counter_irq), .tick_irq(tick_irq), .compare_event(compare_event),
  .overflow_event(overflow_event), .tick_event(tick_event));

// ---- sim/rtcpt_sink.sv ----
// Purpose: Event-routing model that times the event pulses.
// Assumes: Events are one-cycle pulses on the system clock.
// Notes: Gaps are in system clock cycles.
module rtcpt_sink
  import rtcpt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic compare_event,
  input wire logic overflow_event,
  input wire logic [7:0] tick_event,
  output logic [15:0] ovf_gap,
  output logic [15:0] cmp_gap,
  output logic [15:0] tick_gap,
  output logic [15:0] ovf_count,
  output logic [15:0] tick_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stamp_ff, ovf_at_ff, cmp_at_ff, tick_at_ff; // Time stamps of the last pulses.
  // Stamps overflow, compare and 64-period tick pulses; keeps the overflow and tick gaps and the compare-to-overflow gap.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {stamp_ff, ovf_at_ff, cmp_at_ff, tick_at_ff, ovf_gap, cmp_gap, tick_gap, ovf_count, tick_count} <= '0;
    end else begin
      stamp_ff <= stamp_ff + 16'h0001;
      if (overflow_event) begin
        ovf_gap <= stamp_ff - ovf_at_ff;
        cmp_gap <= stamp_ff - cmp_at_ff;
        ovf_at_ff <= stamp_ff;
        ovf_count <= ovf_count + 16'h0001;
      end
      if (compare_event) cmp_at_ff <= stamp_ff;
      if (tick_event[7]) begin
        tick_gap <= stamp_ff - tick_at_ff;
        tick_at_ff <= stamp_ff;
        tick_count <= tick_count + 16'h0001;
      end
    end
  end
endmodule // rtcpt_sink

// ---- sim/rtcpt_top_bench.sv ----
// Purpose: Self-checking bench for the real-time counter.
// Assumes: Reference levels are made here at 8, 10 and 12 clocks a period.
// Notes: The bus is at least eight times the reference rate.
module rtcpt_top_bench;
  import rtcpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, read, write, ultra_low_power_osc, watch_crystal_osc, crystal_pin_in, cpu_halted;
  logic sleep_standby, waitrequest, counter_irq, tick_irq, compare_event, overflow_event;
  logic [7:0] address, tick_event;
  logic [3:0] byteenable, cnt_a, cnt_b, cnt_c;
  logic [31:0] writedata, readdata, va, vb;
  logic [15:0] ovf_gap, cmp_gap, tick_gap, ovf_count, tick_count, mark;
  int fail_count, checks, n;
  rtcpt_top u_rtcpt_top (.clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ultra_low_power_osc(ultra_low_power_osc), .watch_crystal_osc(watch_crystal_osc),
    .crystal_pin_in(crystal_pin_in), .cpu_halted(cpu_halted), .sleep_standby(sleep_standby),
    .counter_irq(counter_irq), .tick_irq(tick_irq), .compare_event(compare_event),
    .overflow_event(overflow_event), .tick_event(tick_event));
  rtcpt_sink u_rtcpt_sink (.clock(clock), .resetn(resetn), .compare_event(compare_event),
    .overflow_event(overflow_event), .tick_event(tick_event), .ovf_gap(ovf_gap), .cmp_gap(cmp_gap),
    .tick_gap(tick_gap), .ovf_count(ovf_count), .tick_count(tick_count));
  // Clock of 5 ns.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Reference levels; each is far slower than the bus clock.
  always @(posedge clock) begin
    cnt_a <= cnt_a + 4'h1;
    cnt_b <= (cnt_b == 4'h9) ? 4'h0 : cnt_b + 4'h1;
    cnt_c <= (cnt_c == 4'hB) ? 4'h0 : cnt_c + 4'h1;
    ultra_low_power_osc <= cnt_a[2];
    watch_crystal_osc <= (cnt_b < 4'h5);
    crystal_pin_in <= (cnt_c < 4'h6);
  end
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Counts a lost wait as a mismatch and ends the run.
  task automatic timed_out(input string what);
    fail_count++;
    $display("mismatch %s expected done seen timeout", what);
    give_verdict();
  endtask
  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus_op(input logic wr, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    address <= {idx, 2'b00};
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 50) timed_out("bus");
    @(posedge clock);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus_op(1'b0, idx, 32'h0, q);
    check(what, q, exp);
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Waits for the overflow count to pass a mark.
  task automatic wait_ovf(input logic [15:0] goal);
    n = 0;
    while (ovf_count < goal && n < 5000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 5000) timed_out("overflow");
  endtask
  // Waits for one compare (0) or overflow (1) pulse.
  task automatic wait_ev(input int which);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(which == 0 ? compare_event : overflow_event) && n < 2000);
    if (n >= 2000) timed_out("event");
  endtask
  initial begin
    {read, write, cpu_halted, sleep_standby, ultra_low_power_osc, watch_crystal_osc, crystal_pin_in} = '0;
    {cnt_a, cnt_b, cnt_c, address, writedata} = '0;
    byteenable = 4'hF;
    fail_count = 0;
    checks = 0;
    resetn = 1'b0;
    cycles(3);
    resetn <= 1'b1;
    @(posedge clock);
    rd(RTCPT_PERIOD_IDX, 32'h0000FFFF, "period reset");
    rd(RTCPT_SRC_IDX, 32'h0, "source reset");
    wr(6'h04, 32'hFF);
    rd(6'h04, 32'h0, "unmapped");
    // Hand-over of a period write waits for the next reference edge.
    n = 0;
    while (!(ultra_low_power_osc === 1'b0 && cnt_a[2] === 1'b1) && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) timed_out("reference edge");
    wr(RTCPT_PERIOD_IDX, 32'h3);
    rd(RTCPT_STATUS_IDX, 32'h4, "period busy");
    cycles(16);
    rd(RTCPT_STATUS_IDX, 32'h0, "busy cleared");
    // Configure first, enable last; prescaler exponent 1.
    wr(RTCPT_COMPARE_IDX, 32'h1);
    wr(RTCPT_IRQ_EN_IDX, 32'h3);
    wr(RTCPT_CTRL_IDX, 32'h09);
    wait_ovf(16'h0002);
    check("overflow gap", 32'(ovf_gap), 32'h40);
    check("compare to overflow", 32'(cmp_gap), 32'h20);
    check("irq set", 32'(counter_irq), 32'h1);
    wr(RTCPT_IRQ_EN_IDX, 32'h1);
    wr(RTCPT_FLAGS_IDX, 32'h3);
    wait_ev(0);
    cycles(3);
    check("compare masked", 32'(counter_irq), 32'h0);
    wait_ev(1);
    cycles(3);
    check("overflow irq", 32'(counter_irq), 32'h1);
    // Halt and standby gating: bits are halted, run-while-halted, standby, standby-run.
    for (int c = 0; c < 4; c++) begin
      cpu_halted <= (c < 2);
      sleep_standby <= (c >= 2);
      wr(RTCPT_DEBUG_IDX, 32'(c == 1));
      wr(RTCPT_CTRL_IDX, (c == 3) ? 32'h89 : 32'h09);
      cycles(20);
      bus_op(1'b0, RTCPT_COUNT_IDX, 32'h0, va);
      cycles(40);
      bus_op(1'b0, RTCPT_COUNT_IDX, 32'h0, vb);
      check("count moves", 32'(va !== vb), 32'(c[0]));
    end
    cpu_halted <= 1'b0;
    sleep_standby <= 1'b0;
    // Every source; overflow every two ticks with period 1.
    wr(RTCPT_PERIOD_IDX, 32'h1);
    wr(RTCPT_CTRL_IDX, 32'h01);
    for (int s = 0; s < 4; s++) begin
      wr(RTCPT_SRC_IDX, 32'(s));
      mark = ovf_count + 16'h0003;
      wait_ovf(mark);
      check("source gap", 32'(ovf_gap), (s == 0) ? 32'h10 : (s == 1) ? 32'h200 : (s == 2) ? 32'h14 : 32'h18);
    end
    // Tick unit alone on the external source, select 1 (four periods).
    wr(RTCPT_CTRL_IDX, 32'h00);
    wr(RTCPT_TICK_IRQ_EN_IDX, 32'h1);
    wr(RTCPT_TICK_CTRL_IDX, 32'h09);
    n = 0;
    while (tick_count < 16'h0002 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000) timed_out("tick");
    check("tick event gap", 32'(tick_gap), 32'h300);
    check("tick irq", 32'(tick_irq), 32'h1);
    wr(RTCPT_TICK_FLAG_IDX, 32'h1);
    check("tick irq cleared", 32'(tick_irq), 32'h0);
    n = 0;
    while (tick_irq !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    check("tick irq interval", 32'(n >= 40 && n <= 52), 32'h1);
    // The tick unit stops under a debug halt unless its own run-while-halted bit is set.
    for (int h = 0; h < 2; h++) begin
      wr(RTCPT_TICK_DEBUG_IDX, 32'(h));
      cpu_halted <= 1'b1;
      mark = tick_count;
      cycles(800);
      check("tick halted", 32'(tick_count != mark), 32'(h));
    end
    cpu_halted <= 1'b0;
    give_verdict();
  end
endmodule // rtcpt_top_bench
